// ### core/dbg_freeze_pkg.sv
/*
 * Constants for the MCU debug freeze and stop-mode control block:
 * register offsets, field positions, write masks and reset values.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package dbg_freeze_pkg;

	// ==========================================================
	// Bus geometry
	localparam int          ADDR_W      = 5;
	localparam int          DATA_W      = 32;
	localparam int          BE_W        = 4;
	localparam logic [3:0]  BE_FULL     = 4'hF;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [4:0]  OFS_IDENT   = 5'h00;
	localparam logic [4:0]  OFS_CONFIG  = 5'h04;
	localparam logic [4:0]  OFS_FZ_ONE  = 5'h08;
	localparam logic [4:0]  OFS_FZ_TWO  = 5'h0C;
	localparam logic [4:0]  OFS_SMBUS   = 5'h10;

	// ==========================================================
	// Field positions
	localparam int          BIT_KEEP_CLOCKS  = 1;
	localparam int          BIT_LOW_POWER_TIMER        = 31;
	localparam int          BIT_INDEPENDENT_WATCHDOG         = 12;
	localparam int          BIT_WINDOWED_WATCHDOG         = 11;
	localparam int          BIT_CAL          = 10;
	localparam int          BIT_TIM3         = 1;
	localparam int          BIT_TIM17        = 18;
	localparam int          BIT_TIM16        = 17;
	localparam int          BIT_TIM14        = 15;
	localparam int          BIT_TIM1         = 11;
	localparam int          BIT_SMBUS        = 0;

	// ==========================================================
	// Writable bits; all others read as zero
	localparam logic [31:0] MASK_CONFIG = 32'h0000_0002;
	localparam logic [31:0] MASK_FZ_ONE = 32'h8000_1C02;
	localparam logic [31:0] MASK_FZ_TWO = 32'h0006_8800;
	localparam logic [31:0] MASK_SMBUS  = 32'h0000_0001;
	localparam logic [31:0] RESET_ZERO  = 32'h0000_0000;

	// Default identification value, arbitrary
	localparam logic [31:0] IDENT_DEFAULT = 32'h0000_1234;

	// ==========================================================
	// Frozen counter channels
	localparam int          NUM_FREEZE  = 10;

	typedef enum logic [3:0] {
		CH_LOW_POWER_TIMER,
		CH_INDEPENDENT_WATCHDOG,
		CH_WINDOWED_WATCHDOG,
		CH_CAL,
		CH_TIM3,
		CH_TIM17,
		CH_TIM16,
		CH_TIM14,
		CH_TIM1,
		CH_SMBUS
	} freeze_ch_t;

	typedef enum logic [1:0] {
		PM_RUN,
		PM_SLEEP,
		PM_STOP
	} power_mode_t;

endpackage

// ### core/freeze_gate_if.sv
/*
 * Carrier between the register file and the halt freeze gate.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface freeze_gate_if
	import dbg_freeze_pkg::*;
	();
	logic [NUM_FREEZE-1:0] freeze_sel;
	logic                  cpu_halted;
	logic [NUM_FREEZE-1:0] count_enable;

	modport ctrl (output freeze_sel, output cpu_halted, input count_enable);
	modport gate (input freeze_sel, input cpu_halted, output count_enable);
endinterface

// ### core/halt_freeze_gate.sv
/*
 * Per-counter enable gate: a counter is stopped while the CPU is halted
 * and its freeze bit is set. Assumes halt status synchronous to clock.
 */
`timescale 1ns/1ps
module halt_freeze_gate
	import dbg_freeze_pkg::*;
(
	input  wire logic     clock,
	input  wire logic     por_rst,
	input  wire logic     clk_en,
	freeze_gate_if.gate   fg
);
	import dbg_freeze_pkg::*;

	// ==========================================================
	// One registered enable per counter
	genvar i;
	generate
		for (i = 0; i < NUM_FREEZE; i++)
		begin : g_ch
			always_ff @(posedge clock or posedge por_rst)
			begin
				if (por_rst)
					fg.count_enable[i] <= 1'b1;
				else if (clk_en)
					fg.count_enable[i] <= !(fg.cpu_halted && fg.freeze_sel[i]);
			end
		end
	endgenerate

endmodule

// ### core/mcu_debug_freeze_control.sv
/*
 * MCU debug box: identification, stop-mode clock retention and
 * per-peripheral halt freeze, on an Avalon-MM slave with waitrequest.
 * Assumes the debug port and CPU bus are merged into one master upstream,
 * and that all inputs are synchronous to clock.
 * Power-on reset clears the registers; system reset only the mode logic.
 */
`timescale 1ns/1ps
module mcu_debug_freeze_control
	import dbg_freeze_pkg::*;
#(
	parameter logic [31:0] IDENT_VALUE = IDENT_DEFAULT
)
(
	input  wire logic                              clock,
	input  wire logic                              rst,
	input  wire logic                              por_rst,
	input  wire logic                              clk_en,
	input  wire logic [dbg_freeze_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                              avs_read,
	input  wire logic                              avs_write,
	input  wire logic [dbg_freeze_pkg::DATA_W-1:0] avs_writedata,
	input  wire logic [dbg_freeze_pkg::BE_W-1:0]   avs_byteenable,
	output logic      [dbg_freeze_pkg::DATA_W-1:0] avs_readdata,
	output logic                                   avs_waitrequest,
	input  wire logic                              cpu_halted,
	input  wire logic                              debug_session,
	input  wire logic                              sleep_request,
	input  wire logic                              stop_request,
	input  wire logic                              wake_event,
	output logic                                   core_clock_enable,
	output logic                                   bus_clock_enable,
	output logic                                   rc_osc_enable,
	output logic                                   restore_reset_clocks,
	output logic                                   lowpower_timer_count_en,
	output logic                                   independent_watchdog_count_en,
	output logic                                   windowed_watchdog_count_en,
	output logic                                   calendar_count_en,
	output logic                                   timer_three_count_en,
	output logic                                   timer_seventeen_count_en,
	output logic                                   timer_sixteen_count_en,
	output logic                                   timer_fourteen_count_en,
	output logic                                   advanced_timer_count_en,
	output logic                                   smbus_timeout_count_en
);
	import dbg_freeze_pkg::*;

	// ==========================================================
	// Registers
	logic [31:0]  stop_debug_config;
	logic [31:0]  halt_freeze_one;
	logic [31:0]  halt_freeze_two;
	logic [31:0]  smbus_freeze;
	logic [31:0]  lane_mask;
	logic         access_done;
	logic         bus_write;
	logic [31:0]  next_readdata;
	power_mode_t  power_mode;
	logic         clocks_dropped;
	logic         request_taken;
	logic         ident_full_word;
	logic         write_config;
	logic         write_fz_one;
	logic         write_fz_two;
	logic         write_smbus;
	logic [31:0]  next_stop_debug_config;
	logic [31:0]  next_halt_freeze_one;
	logic [31:0]  next_halt_freeze_two;
	logic [31:0]  next_smbus_freeze;
	logic         stop_exit;
	logic         clocks_off;

	freeze_gate_if fgi ();

	// Byte lanes turned into a bit mask
	genvar b;
	generate
		for (b = 0; b < BE_W; b++)
		begin : g_lane
			assign lane_mask[8*b +: 8] = {8{avs_byteenable[b]}};
		end
	endgenerate

	// ==========================================================
	// Avalon handshake
	// One wait cycle: request seen, then waitrequest low for one cycle.
	// Reset only by power-on so the debugger can work under system reset.
	assign request_taken = (avs_read || avs_write) && avs_waitrequest && !access_done;

	always_ff @(posedge clock or posedge por_rst)
	begin
		if (por_rst)
			avs_waitrequest <= 1'b1;
		else if (clk_en)
		begin
			if (request_taken)
				avs_waitrequest <= 1'b0;
			else
				avs_waitrequest <= 1'b1;
		end
	end

	// Blocks a second answer in the cycle after an answer; a request still held after that is answered again
	always_ff @(posedge clock or posedge por_rst)
	begin
		if (por_rst)
			access_done <= 1'b0;
		else if (clk_en)
			access_done <= !avs_waitrequest;
	end

	// Writes from either the debugger or the CPU share this path
	assign bus_write = avs_write && !avs_waitrequest;

	// ==========================================================
	// Address decode and masked merge
	// Identification and unmapped offsets get no strobe, so writes vanish
	assign write_config = bus_write && avs_address == OFS_CONFIG;
	assign write_fz_one = bus_write && avs_address == OFS_FZ_ONE;
	assign write_fz_two = bus_write && avs_address == OFS_FZ_TWO;
	assign write_smbus  = bus_write && avs_address == OFS_SMBUS;

	// Only enabled lanes of writable bits change; reserved bits stay zero
	assign next_stop_debug_config = (stop_debug_config & ~(lane_mask & MASK_CONFIG))
		| (avs_writedata & lane_mask & MASK_CONFIG);
	assign next_halt_freeze_one   = (halt_freeze_one & ~(lane_mask & MASK_FZ_ONE))
		| (avs_writedata & lane_mask & MASK_FZ_ONE);
	assign next_halt_freeze_two   = (halt_freeze_two & ~(lane_mask & MASK_FZ_TWO))
		| (avs_writedata & lane_mask & MASK_FZ_TWO);
	assign next_smbus_freeze      = (smbus_freeze & ~(lane_mask & MASK_SMBUS))
		| (avs_writedata & lane_mask & MASK_SMBUS);

	// ==========================================================
	// Read mux
	// Narrower reads of the identification word answer with zero
	assign ident_full_word = avs_byteenable == BE_FULL;

	always_comb
	begin
		next_readdata = RESET_ZERO;
		case (avs_address)
			OFS_IDENT:
			begin
				if (ident_full_word)
					next_readdata = IDENT_VALUE;
			end
			OFS_CONFIG: next_readdata = stop_debug_config;
			OFS_FZ_ONE: next_readdata = halt_freeze_one;
			OFS_FZ_TWO: next_readdata = halt_freeze_two;
			OFS_SMBUS:  next_readdata = smbus_freeze;
			default:    next_readdata = RESET_ZERO;
		endcase
	end

	always_ff @(posedge clock or posedge por_rst)
	begin
		if (por_rst)
			avs_readdata <= RESET_ZERO;
		else if (clk_en)
		begin
			if (avs_read && request_taken)
				avs_readdata <= next_readdata;
		end
	end

	// ==========================================================
	// Configuration registers: power-on reset only, system reset ignored
	always_ff @(posedge clock or posedge por_rst)
	begin
		if (por_rst)
			stop_debug_config <= RESET_ZERO;
		else if (clk_en && write_config)
			stop_debug_config <= next_stop_debug_config;
	end

	always_ff @(posedge clock or posedge por_rst)
	begin
		if (por_rst)
			halt_freeze_one <= RESET_ZERO;
		else if (clk_en && write_fz_one)
			halt_freeze_one <= next_halt_freeze_one;
	end

	always_ff @(posedge clock or posedge por_rst)
	begin
		if (por_rst)
			halt_freeze_two <= RESET_ZERO;
		else if (clk_en && write_fz_two)
			halt_freeze_two <= next_halt_freeze_two;
	end

	always_ff @(posedge clock or posedge por_rst)
	begin
		if (por_rst)
			smbus_freeze <= RESET_ZERO;
		else if (clk_en && write_smbus)
			smbus_freeze <= next_smbus_freeze;
	end

	// ==========================================================
	// Halt freeze selection
	assign fgi.cpu_halted            = cpu_halted;
	assign fgi.freeze_sel[CH_LOW_POWER_TIMER]  = halt_freeze_one[BIT_LOW_POWER_TIMER];
	assign fgi.freeze_sel[CH_INDEPENDENT_WATCHDOG]   = halt_freeze_one[BIT_INDEPENDENT_WATCHDOG];
	assign fgi.freeze_sel[CH_WINDOWED_WATCHDOG]   = halt_freeze_one[BIT_WINDOWED_WATCHDOG];
	assign fgi.freeze_sel[CH_CAL]    = halt_freeze_one[BIT_CAL];
	assign fgi.freeze_sel[CH_TIM3]   = halt_freeze_one[BIT_TIM3];
	assign fgi.freeze_sel[CH_TIM17]  = halt_freeze_two[BIT_TIM17];
	assign fgi.freeze_sel[CH_TIM16]  = halt_freeze_two[BIT_TIM16];
	assign fgi.freeze_sel[CH_TIM14]  = halt_freeze_two[BIT_TIM14];
	assign fgi.freeze_sel[CH_TIM1]   = halt_freeze_two[BIT_TIM1];
	assign fgi.freeze_sel[CH_SMBUS]  = smbus_freeze[BIT_SMBUS];

	halt_freeze_gate u_gate (
		.clock   (clock),
		.por_rst (por_rst),
		.clk_en  (clk_en),
		.fg      (fgi.gate)
	);

	// Gate enables are flops inside the gate module
	assign lowpower_timer_count_en       = fgi.count_enable[CH_LOW_POWER_TIMER];
	assign independent_watchdog_count_en = fgi.count_enable[CH_INDEPENDENT_WATCHDOG];
	assign windowed_watchdog_count_en    = fgi.count_enable[CH_WINDOWED_WATCHDOG];
	assign calendar_count_en             = fgi.count_enable[CH_CAL];
	assign timer_three_count_en          = fgi.count_enable[CH_TIM3];
	assign timer_seventeen_count_en      = fgi.count_enable[CH_TIM17];
	assign timer_sixteen_count_en        = fgi.count_enable[CH_TIM16];
	assign timer_fourteen_count_en       = fgi.count_enable[CH_TIM14];
	assign advanced_timer_count_en       = fgi.count_enable[CH_TIM1];
	assign smbus_timeout_count_en        = fgi.count_enable[CH_SMBUS];

	// ==========================================================
	// Low-power mode sequencing
	// The host must set the keep bit before Stop; a session or keep bit that arrives
	// after the clocks were dropped turns them back on while still in Stop.
	always_ff @(posedge clock)
	begin
		if (rst)
			power_mode <= PM_RUN;
		else if (clk_en)
		begin
			case (power_mode)
				PM_RUN:
				begin
					if (stop_request)
						power_mode <= PM_STOP;
					else if (sleep_request)
						power_mode <= PM_SLEEP;
				end
				PM_SLEEP:
				begin
					if (wake_event)
						power_mode <= PM_RUN;
				end
				PM_STOP:
				begin
					if (wake_event)
						power_mode <= PM_RUN;
				end
				default: power_mode <= PM_RUN;
			endcase
		end
	end

	// ==========================================================
	// Clock enables
	// Stop ends on the first wake event seen while in Stop
	assign stop_exit = power_mode == PM_STOP && wake_event;

	// Clocks drop only in Stop, without the keep bit, outside a session
	assign clocks_off = power_mode == PM_STOP && !wake_event
		&& !stop_debug_config[BIT_KEEP_CLOCKS] && !debug_session;

	// One block per clock so each can later get its own gating condition
	always_ff @(posedge clock)
	begin
		if (rst)
			core_clock_enable <= 1'b1;
		else if (clk_en)
			core_clock_enable <= !clocks_off;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			bus_clock_enable <= 1'b1;
		else if (clk_en)
			bus_clock_enable <= !clocks_off;
	end

	// The oscillator feeds both clocks whenever they must keep running
	always_ff @(posedge clock)
	begin
		if (rst)
			rc_osc_enable <= 1'b1;
		else if (clk_en)
			rc_osc_enable <= !clocks_off;
	end

	// Remembers that Stop really stopped the clocks
	always_ff @(posedge clock)
	begin
		if (rst)
			clocks_dropped <= 1'b0;
		else if (clk_en)
		begin
			if (power_mode != PM_STOP)
				clocks_dropped <= 1'b0;
			else if (!core_clock_enable)
				clocks_dropped <= 1'b1;
		end
	end

	// One pulse on Stop exit after clocks were dropped: clock setup returns to the reset setup
	always_ff @(posedge clock)
	begin
		if (rst)
			restore_reset_clocks <= 1'b0;
		else if (clk_en)
			restore_reset_clocks <= stop_exit && (clocks_dropped || !core_clock_enable);
	end

endmodule

// ### verif/dbg_freeze_chk_sva.sv
/* Checker for the debug freeze block: bus handshake, read data, gates.
 * Assumes one clock domain; power-on reset disables all checks. */
`timescale 1ns/1ps
module dbg_freeze_chk
	import dbg_freeze_pkg::*;
#(
	parameter logic [31:0] IDENT_VALUE = IDENT_DEFAULT
)
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        por_rst,
	input wire logic        clk_en,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        cpu_halted,
	input wire logic        debug_session,
	input wire logic        core_clock_enable,
	input wire logic        bus_clock_enable,
	input wire logic        rc_osc_enable,
	input wire logic        restore_reset_clocks,
	input wire logic        lowpower_timer_count_en,
	input wire logic        independent_watchdog_count_en,
	input wire logic        windowed_watchdog_count_en,
	input wire logic        calendar_count_en,
	input wire logic        timer_three_count_en,
	input wire logic        timer_seventeen_count_en,
	input wire logic        timer_sixteen_count_en,
	input wire logic        timer_fourteen_count_en,
	input wire logic        advanced_timer_count_en,
	input wire logic        smbus_timeout_count_en
);
	logic        rd_done;
	logic [31:0] rd_mask;
	logic        all_en;
	assign rd_done = !avs_waitrequest && avs_read;
	// Unmapped places leave no bit free
	assign rd_mask = (avs_address == OFS_IDENT) ? 32'hFFFF_FFFF :
		(avs_address == OFS_CONFIG) ? MASK_CONFIG : (avs_address == OFS_FZ_ONE) ? MASK_FZ_ONE :
		(avs_address == OFS_FZ_TWO) ? MASK_FZ_TWO : (avs_address == OFS_SMBUS) ? MASK_SMBUS : '0;
	assign all_en = lowpower_timer_count_en & independent_watchdog_count_en &
		windowed_watchdog_count_en & calendar_count_en & timer_three_count_en &
		timer_seventeen_count_en & timer_sixteen_count_en & timer_fourteen_count_en &
		advanced_timer_count_en & smbus_timeout_count_en;

	default clocking cb @(posedge clock); endclocking
	default disable iff (por_rst);

	// ========
	// Sequences
	sequence answer_s;
		##[1:3] !avs_waitrequest ##1 avs_waitrequest;
	endsequence
	sequence restore_s;
		core_clock_enable && bus_clock_enable ##1 !restore_reset_clocks;
	endsequence

	// ========
	// Properties
	bus_answer_a: assert property ($rose(avs_read || avs_write) && clk_en |-> answer_s)
		else $error("bus answer late or too long");
	answer_req_a: assert property (!avs_waitrequest |-> avs_read || avs_write)
		else $error("answer without request");
	ident_value_a: assert property (rd_done && avs_address == OFS_IDENT && avs_byteenable == BE_FULL |-> avs_readdata == IDENT_VALUE)
		else $error("ident read wrong");
	ident_part_a: assert property (rd_done && avs_address == OFS_IDENT && avs_byteenable != BE_FULL |-> avs_readdata == '0)
		else $error("partial ident read not zero");
	reserved_zero_a: assert property (rd_done |-> (avs_readdata & ~rd_mask) == '0)
		else $error("reserved bits not zero");
	run_free_a: assert property (!$past(cpu_halted) && $past(clk_en) |-> all_en)
		else $error("counter stopped while running");
	session_on_a: assert property ($past(debug_session) && $past(clk_en) |-> core_clock_enable && bus_clock_enable)
		else $error("clocks off in debug session");
	clock_pair_a: assert property (core_clock_enable == bus_clock_enable)
		else $error("core and bus clock differ");
	restore_pulse_a: assert property (restore_reset_clocks |-> restore_s)
		else $error("restore pulse wrong");
	sys_reset_a: assert property ($past(rst) && $past(clk_en) |-> core_clock_enable && rc_osc_enable && !restore_reset_clocks)
		else $error("system reset clocks wrong");
endmodule

bind mcu_debug_freeze_control dbg_freeze_chk #(.IDENT_VALUE(IDENT_VALUE)) chk (.*);

// ### verif/debug_host.sv
/* Debug host model: Avalon-MM master doing one transfer at a time.
 * Assumes the slave answers with waitrequest low on a rising edge. */
`timescale 1ns/1ps
module debug_host
	import dbg_freeze_pkg::*;
(
	input  wire logic        clock,
	output logic      [4:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	initial
	begin
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = '0;
	end

	// Released address and data lines show inverted values so stale data never looks valid
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		// Waits as long as the slave asks; only the bench watchdog ends a hang
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask

	// Keep bit goes in before any Stop request
	task automatic arm_stop(input logic [31:0] cfg);
		logic [31:0] q;
		xfer(1'b1, OFS_CONFIG, cfg, BE_FULL, q);
	endtask
endmodule

// ### verif/test_mcu_debug_freeze_control.sv
/* Testbench for the debug freeze block: table of register cases, then
 * freeze map, resets and power modes. Assumes clk_en held high. */
`timescale 1ns/1ps
module test_mcu_debug_freeze_control;
	import dbg_freeze_pkg::*;
	typedef struct { logic [4:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] exp; } row_t;
	localparam logic [31:0] ID = 32'h0000_5A3C; // Arbitrary value
	logic clock, rst, por_rst, cpu_halted, debug_session, sleep_request, stop_request, wake_event;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0]  avs_byteenable;
	logic        avs_read, avs_write, avs_waitrequest;
	logic        core_clock_enable, bus_clock_enable, rc_osc_enable, restore_reset_clocks;
	logic [9:0]  cen;
	int          fail_count, n_checks;
	row_t rows[8] = '{'{OFS_CONFIG, 32'hFFFF_FFFF, BE_FULL, 32'h0000_0002},
		'{OFS_FZ_ONE, 32'hFFFF_FFFF, BE_FULL, 32'h8000_1C02},
		'{OFS_FZ_TWO, 32'hFFFF_FFFF, BE_FULL, 32'h0006_8800},
		'{OFS_SMBUS, 32'hFFFF_FFFF, BE_FULL, 32'h0000_0001},
		'{OFS_FZ_ONE, 32'h0000_0000, 4'h1, 32'h8000_1C00},
		'{OFS_IDENT, 32'hFFFF_FFFF, BE_FULL, ID},
		'{5'h14, 32'hFFFF_FFFF, BE_FULL, 32'h0000_0000},
		'{OFS_CONFIG, 32'h0000_0000, BE_FULL, 32'h0000_0000}};
	logic [4:0] fa[10] = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h0C, 5'h0C, 5'h0C, 5'h0C, 5'h10};
	int fb[10] = '{31, 12, 11, 10, 1, 18, 17, 15, 11, 0};

	mcu_debug_freeze_control #(.IDENT_VALUE(ID)) dut (.clock, .rst, .por_rst, .clk_en(1'b1),
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .cpu_halted, .debug_session, .sleep_request, .stop_request,
		.wake_event, .core_clock_enable, .bus_clock_enable, .rc_osc_enable, .restore_reset_clocks,
		.lowpower_timer_count_en(cen[9]), .independent_watchdog_count_en(cen[8]),
		.windowed_watchdog_count_en(cen[7]), .calendar_count_en(cen[6]),
		.timer_three_count_en(cen[5]), .timer_seventeen_count_en(cen[4]),
		.timer_sixteen_count_en(cen[3]), .timer_fourteen_count_en(cen[2]),
		.advanced_timer_count_en(cen[1]), .smbus_timeout_count_en(cen[0]));
	debug_host host (.clock, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, BE_FULL, q);
	endtask
	task automatic rd(input logic [4:0] a);
		host.xfer(1'b0, a, 32'h0000_0000, BE_FULL, q);
	endtask
	task automatic mode_case(input logic stp, input logic [31:0] cfg, input logic ses, input logic on);
		host.arm_stop(cfg);
		@(posedge clock);
		debug_session <= ses;
		stop_request <= stp;
		sleep_request <= !stp;
		@(posedge clock);
		stop_request <= 1'b0;
		sleep_request <= 1'b0;
		@(posedge clock);
		#1;
		check("core clock", core_clock_enable, on);
		check("bus clock", bus_clock_enable, on);
		if (cfg[1]) check("rc osc", rc_osc_enable, 1'b1);
		@(posedge clock);
		wake_event <= 1'b1;
		@(posedge clock);
		wake_event <= 1'b0;
		debug_session <= 1'b0;
		#1;
		check("restore", restore_reset_clocks, !on);
		check("core after wake", core_clock_enable, 1'b1);
		$display("power case done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clock);
		fail_count++;
		$display("ERROR watchdog expected done seen hang");
		finish_test();
	end

	initial
	begin
		{rst, por_rst} = 2'b11;
		{cpu_halted, debug_session, sleep_request, stop_request, wake_event} = '0;
		fail_count = 0;
		n_checks = 0;
		repeat (20) @(posedge clock);
		por_rst <= 1'b0;
		rst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rd(5'(4 * i));
			check("reset value", q, (i == 0) ? ID : 32'h0000_0000);
		end
		$display("reset values done");
		foreach (rows[i])
		begin
			host.xfer(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
			rd(rows[i].a);
			check("register row", q, rows[i].exp);
		end
		host.xfer(1'b0, OFS_IDENT, 32'h0000_0000, 4'h3, q);
		check("ident partial", q, 32'h0000_0000);
		$display("register rows done");
		wr(OFS_FZ_ONE, 32'h0000_0000);
		wr(OFS_FZ_TWO, 32'h0000_0000);
		wr(OFS_SMBUS, 32'h0000_0000);
		@(posedge clock);
		cpu_halted <= 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			wr(fa[i], 32'h0000_0001 << fb[i]);
			repeat (2) @(posedge clock);
			#1;
			check("freeze map", {22'h0, cen}, {22'h0, ~(10'h200 >> i)});
			wr(fa[i], 32'h0000_0000);
		end
		cpu_halted <= 1'b0;
		$display("freeze map done");
		wr(OFS_CONFIG, 32'h0000_0002);
		@(posedge clock);
		rst <= 1'b1;
		wr(OFS_FZ_TWO, 32'hFFFF_FFFF);
		rst <= 1'b0;
		rd(OFS_CONFIG);
		check("config after rst", q, 32'h0000_0002);
		rd(OFS_FZ_TWO);
		check("write under rst", q, 32'h0006_8800);
		@(posedge clock);
		por_rst <= 1'b1;
		@(posedge clock);
		por_rst <= 1'b0;
		rd(OFS_CONFIG);
		check("config after por", q, 32'h0000_0000);
		rd(OFS_FZ_TWO);
		check("freeze after por", q, 32'h0000_0000);
		$display("reset cases done");
		mode_case(1'b1, 32'h0000_0000, 1'b0, 1'b0);
		mode_case(1'b1, 32'h0000_0002, 1'b0, 1'b1);
		mode_case(1'b1, 32'h0000_0000, 1'b1, 1'b1);
		mode_case(1'b0, 32'h0000_0000, 1'b0, 1'b1);
		finish_test();
	end
endmodule
